// >>> pkg/sssxo_pkg.sv
// package: constants, opcodes and carriers of the sub/swap/skip/xor datapath
// Contract
// [RL1] subtract: carry clear if negative, update flags
// [RL2] memory subtract writes acc minus byte back
// [RL3] immediate subtract puts acc minus constant in acc
// [RL4] nibble exchange in place, no flag change
// [RL5] exchange to acc, memory byte left unchanged
// [RL6] byte test rewrites byte, skips when zero
// [RL7] copy-and-test loads acc, skips when zero
// [RL8] bit test skips only when bit is 0
// [RL9] skips take two cycles, alter no flags
// [RL10] current-page table read: low to memory, high latched
// [RL11] last-page table read from last page plus lower
// [RL12] xor into acc updates only zero flag
// [RL13] xor into memory updates only zero flag
// [RL14] immediate xor into acc updates only zero
// [RL15] taken skip discards next, counter passes it
package sssxo_pkg;
    localparam int DM_AW = 5;
    localparam int PM_AW = 10;
    localparam int PM_DW = 16;
    localparam int BUS_AW = 8;
    localparam logic [BUS_AW-1:0] REG_CMD = 8'h00;
    localparam logic [BUS_AW-1:0] REG_STAT = 8'h04;
    localparam logic [BUS_AW-1:0] REG_ACC = 8'h08;
    localparam logic [BUS_AW-1:0] REG_TBL = 8'h0C;
    localparam logic [BUS_AW-1:0] REG_PADDR = 8'h10;
    localparam logic [BUS_AW-1:0] REG_PDATA = 8'h14;
    localparam logic [BUS_AW-1:0] DM_WIN = 8'h80;
    localparam int ST_BUSY = 0;
    localparam int ST_SKIP = 1;
    localparam int ST_FLAG = 4;
    localparam int ST_PC = 16;
    localparam int TB_UPPER = 8;
    localparam int TB_HIGH = 16;
    localparam logic TBL_HAS_UPPER = 1'b1;
    localparam logic [PM_AW-9:0] LAST_PAGE = 2'h3;
    localparam logic [PM_AW-1:0] PC_STEP = 10'h001;
    localparam logic [PM_AW-1:0] PC_SKIP_STEP = 10'h002;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [PM_AW-1:0] PC_RST = 10'h000;
    typedef enum logic [3:0] {
        OP_NOP, OP_SUB_IMM, OP_SUBTRACT_TO_MEMORY, OP_NIBBLE_EXCHANGE,
        OP_NIBBLE_EXCHANGE_TO_ACC, OP_SKIP_IF_ZERO, OP_COPY_AND_SKIP_IF_ZERO,
        OP_SKIP_IF_BIT_ZERO, OP_TABLE_READ_CURRENT, OP_TABLE_READ_LAST_PAGE,
        OP_XOR_ACC, OP_EXCLUSIVE_OR_TO_MEMORY, OP_XOR_IMM
    } sssxo_op_t;
    typedef struct packed {
        logic overflow_flag;
        logic z;
        logic aux_carry_flag;
        logic c;
    } sssxo_flags_t;
    typedef struct packed {
        logic [7:0] imm;
        logic [2:0] bitsel;
        logic [DM_AW-1:0] addr;
        sssxo_op_t op;
    } sssxo_cmd_t;
    localparam int CMD_W = $bits(sssxo_cmd_t);
    localparam sssxo_flags_t FLAGS_RST = 4'h0;
    localparam sssxo_cmd_t CMD_RST = 20'h00000;
endpackage

// >>> design/sssxo_mem.sv
// single-port synchronous ram with registered read data
`timescale 1ns/1ps
`default_nettype none
module sssxo_mem #(
    parameter int AW = 5,
    parameter int DW = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] next_rdata;

    // old data read out while a write lands
    always_comb begin
        next_rdata = mem[addr];
    end

    // storage and output register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
        if (we) begin
            mem[addr] <= wdata;
        end
    end
endmodule
`default_nettype wire

// >>> design/sssxo_alu.sv
// combinational compute unit: subtract, swap, zero tests, xor
`timescale 1ns/1ps
`default_nettype none
module sssxo_alu (
    input wire sssxo_pkg::sssxo_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] mem_byte,
    input wire logic [7:0] imm,
    input wire logic [2:0] bitsel,
    input wire sssxo_pkg::sssxo_flags_t flags_in,
    output var sssxo_pkg::sssxo_flags_t flags_out,
    output logic [7:0] operand,
    output logic [7:0] result,
    output logic to_acc,
    output logic to_mem,
    output logic skip
);
    import sssxo_pkg::*;
    logic [8:0] diff;
    logic [4:0] low_diff;

    // operation decode, flags held unless the op names them
    always_comb begin
        operand = (op == OP_SUB_IMM || op == OP_XOR_IMM) ? imm : mem_byte;
        diff = {1'b0, acc} - {1'b0, operand};
        low_diff = {1'b0, acc[3:0]} - {1'b0, operand[3:0]};
        result = mem_byte;
        to_acc = 1'b0;
        to_mem = 1'b0;
        skip = 1'b0;
        flags_out = flags_in;
        case (op)
            OP_SUB_IMM, OP_SUBTRACT_TO_MEMORY: begin
                result = diff[7:0];
                to_acc = (op == OP_SUB_IMM); // [RL3]
                to_mem = (op == OP_SUBTRACT_TO_MEMORY); // [RL2]
                flags_out.c = ~diff[8]; // [RL1]
                flags_out.aux_carry_flag = ~low_diff[4];
                flags_out.overflow_flag = (acc[7] ^ operand[7]) & (acc[7] ^ diff[7]);
                flags_out.z = (diff[7:0] == 8'h00);
            end
            OP_NIBBLE_EXCHANGE: begin
                result = {mem_byte[3:0], mem_byte[7:4]};
                to_mem = 1'b1; // [RL4]
            end
            OP_NIBBLE_EXCHANGE_TO_ACC: begin
                result = {mem_byte[3:0], mem_byte[7:4]};
                to_acc = 1'b1; // [RL5]
            end
            OP_SKIP_IF_ZERO: begin
                to_mem = 1'b1;
                skip = (mem_byte == 8'h00); // [RL6]
            end
            OP_COPY_AND_SKIP_IF_ZERO: begin
                to_acc = 1'b1;
                skip = (mem_byte == 8'h00); // [RL7]
            end
            OP_SKIP_IF_BIT_ZERO: begin
                skip = ~mem_byte[bitsel]; // [RL8]
            end
            OP_XOR_ACC, OP_XOR_IMM, OP_EXCLUSIVE_OR_TO_MEMORY: begin
                result = acc ^ operand;
                to_acc = (op != OP_EXCLUSIVE_OR_TO_MEMORY); // [RL12] [RL14]
                to_mem = (op == OP_EXCLUSIVE_OR_TO_MEMORY); // [RL13]
                flags_out.z = (result == 8'h00);
            end
            default: begin
                result = mem_byte;
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> design/sssxo_top.sv
// datapath top: avalon register slave, execution sequencer, memories
`timescale 1ns/1ps
`default_nettype none
module sssxo_top (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [sssxo_pkg::BUS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic exec_busy,
    output logic skip_taken
);
    import sssxo_pkg::*;
    typedef enum {BUS_IDLE, BUS_MEM, BUS_ACK} sssxo_bus_t;
    typedef enum {EX_IDLE, EX_FETCH, EX_EXEC, EX_DUM1, EX_DUM2} sssxo_ex_t;

    sssxo_bus_t bus_st, next_bus_st;
    sssxo_ex_t ex_st, next_ex_st;
    sssxo_cmd_t cmd, next_cmd;
    sssxo_flags_t flags, next_flags, alu_flags;
    logic [7:0] accumulator, next_accumulator;
    logic [7:0] table_pointer_lower, next_table_pointer_lower;
    logic [PM_AW-9:0] table_pointer_upper, next_table_pointer_upper;
    logic [7:0] table_high_latch, next_table_high_latch;
    logic [PM_AW-1:0] prog_counter, next_prog_counter;
    logic [PM_AW-1:0] prog_addr, next_prog_addr;
    logic [PM_AW-1:0] pm_addr, tbl_addr;
    logic skip_last, next_skip_last;
    logic [31:0] next_rdata, reg_rd, wmask, wv;
    logic next_wreq, next_busy, next_skip_taken;
    logic [DM_AW-1:0] dm_addr;
    logic [7:0] dm_wdata, dm_q, alu_result, alu_opnd, pm_hi;
    logic dm_we, pm_we, alu_to_acc, alu_to_mem, alu_skip;
    logic [PM_DW-1:0] pm_q;
    logic req, win, hold, wr_done, is_skip, is_tbl, bit_zero;

    // byte-lane mask from the enables
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign wmask[8*i +: 8] = {8{avs_byteenable[i]}};
    end

    // bus decode and write merge
    always_comb begin
        req = avs_read | avs_write;
        win = (avs_address >= DM_WIN);
        hold = (ex_st != EX_IDLE) && (win || avs_write || avs_address == REG_PDATA);
        wr_done = (bus_st == BUS_ACK) && avs_write;
        wv = (reg_rd & ~wmask) | (avs_writedata & wmask);
        is_skip = (cmd.op == OP_SKIP_IF_ZERO) || (cmd.op == OP_COPY_AND_SKIP_IF_ZERO)
            || (cmd.op == OP_SKIP_IF_BIT_ZERO);
        is_tbl = (cmd.op == OP_TABLE_READ_CURRENT) || (cmd.op == OP_TABLE_READ_LAST_PAGE);
        bit_zero = ~dm_q[cmd.bitsel];
        pm_hi = pm_q[15:8];
    end

    // register read mux
    always_comb begin
        reg_rd = 32'h0000_0000;
        case (avs_address)
            REG_CMD: reg_rd[CMD_W-1:0] = cmd;
            REG_STAT: begin
                reg_rd[ST_BUSY] = (ex_st != EX_IDLE);
                reg_rd[ST_SKIP] = skip_last;
                reg_rd[ST_FLAG +: 4] = flags;
                reg_rd[ST_PC +: PM_AW] = prog_counter;
            end
            REG_ACC: reg_rd[7:0] = accumulator;
            REG_TBL: begin
                reg_rd[7:0] = table_pointer_lower;
                reg_rd[TB_UPPER +: PM_AW-8] = table_pointer_upper;
                reg_rd[TB_HIGH +: 8] = table_high_latch;
            end
            REG_PADDR: reg_rd[PM_AW-1:0] = prog_addr;
            default: reg_rd = 32'h0000_0000;
        endcase
    end

    // bus state: memory reads take one extra wait cycle
    always_comb begin
        next_bus_st = bus_st;
        next_rdata = avs_readdata;
        case (bus_st)
            BUS_IDLE: begin
                if (req && !hold) begin
                    if (avs_read && (win || avs_address == REG_PDATA)) begin
                        next_bus_st = BUS_MEM;
                    end else begin
                        next_bus_st = BUS_ACK;
                        next_rdata = avs_read ? reg_rd : 32'h0000_0000;
                    end
                end
            end
            BUS_MEM: begin
                next_bus_st = BUS_ACK;
                next_rdata = win ? {24'h00_0000, dm_q} : {16'h0000, pm_q};
            end
            BUS_ACK: next_bus_st = BUS_IDLE;
            default: next_bus_st = BUS_IDLE;
        endcase
        next_wreq = (next_bus_st != BUS_ACK);
    end

    // table address: current page or last page
    always_comb begin
        tbl_addr = {TBL_HAS_UPPER ? table_pointer_upper : prog_counter[PM_AW-1:8], table_pointer_lower}; // [RL10]
        if (cmd.op == OP_TABLE_READ_LAST_PAGE) begin
            tbl_addr = {LAST_PAGE, table_pointer_lower}; // [RL11]
        end
    end

    // register writes and the execution sequence
    always_comb begin
        next_ex_st = ex_st;
        next_cmd = cmd;
        next_accumulator = accumulator;
        next_flags = flags;
        next_table_pointer_lower = table_pointer_lower;
        next_table_pointer_upper = table_pointer_upper;
        next_table_high_latch = table_high_latch;
        next_prog_counter = prog_counter;
        next_prog_addr = prog_addr;
        next_skip_last = skip_last;
        next_skip_taken = 1'b0;
        dm_addr = avs_address[DM_AW+1:2];
        dm_we = 1'b0;
        dm_wdata = wv[7:0];
        pm_addr = prog_addr;
        pm_we = 1'b0;
        if (wr_done) begin
            case (avs_address)
                REG_CMD: begin
                    next_cmd = sssxo_cmd_t'(wv[CMD_W-1:0]);
                    next_ex_st = EX_FETCH;
                end
                REG_STAT: begin
                    next_flags = sssxo_flags_t'(wv[ST_FLAG +: 4]);
                    next_prog_counter = wv[ST_PC +: PM_AW];
                end
                REG_ACC: next_accumulator = wv[7:0];
                REG_TBL: begin
                    next_table_pointer_lower = wv[7:0];
                    next_table_pointer_upper = wv[TB_UPPER +: PM_AW-8];
                end
                REG_PADDR: next_prog_addr = wv[PM_AW-1:0];
                REG_PDATA: begin
                    pm_we = 1'b1;
                    next_prog_addr = prog_addr + PC_STEP;
                end
                default: dm_we = win;
            endcase
        end
        case (ex_st)
            EX_IDLE: next_skip_taken = 1'b0;
            EX_FETCH: begin
                dm_addr = cmd.addr;
                pm_addr = tbl_addr;
                next_ex_st = EX_EXEC;
            end
            EX_EXEC: begin
                dm_addr = cmd.addr;
                next_flags = alu_flags; // [RL1] [RL9]
                if (is_tbl) begin
                    dm_we = 1'b1; // [RL10] [RL11]
                    dm_wdata = pm_q[7:0];
                    next_table_high_latch = pm_hi;
                end else begin
                    dm_we = alu_to_mem;
                    dm_wdata = alu_result;
                    if (alu_to_acc) begin
                        next_accumulator = alu_result;
                    end
                end
                next_skip_last = alu_skip;
                next_skip_taken = alu_skip; // [RL15]
                next_prog_counter = prog_counter + (alu_skip ? PC_SKIP_STEP : PC_STEP); // [RL15]
                next_ex_st = is_skip ? EX_DUM1 : EX_IDLE; // [RL9]
            end
            EX_DUM1: next_ex_st = EX_DUM2;
            EX_DUM2: next_ex_st = EX_IDLE;
            default: next_ex_st = EX_IDLE;
        endcase
        next_busy = (next_ex_st != EX_IDLE);
    end

    // state registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bus_st <= BUS_IDLE;
            ex_st <= EX_IDLE;
            cmd <= CMD_RST;
            flags <= FLAGS_RST;
            accumulator <= ACC_RST;
            table_pointer_lower <= PTR_RST;
            table_pointer_upper <= '0;
            table_high_latch <= PTR_RST;
            prog_counter <= PC_RST;
            prog_addr <= PC_RST;
            skip_last <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
            exec_busy <= 1'b0;
            skip_taken <= 1'b0;
        end else begin
            bus_st <= next_bus_st;
            ex_st <= next_ex_st;
            cmd <= next_cmd;
            flags <= next_flags;
            accumulator <= next_accumulator;
            table_pointer_lower <= next_table_pointer_lower;
            table_pointer_upper <= next_table_pointer_upper;
            table_high_latch <= next_table_high_latch;
            prog_counter <= next_prog_counter;
            prog_addr <= next_prog_addr;
            skip_last <= next_skip_last;
            avs_readdata <= next_rdata;
            avs_waitrequest <= next_wreq;
            exec_busy <= next_busy;
            skip_taken <= next_skip_taken;
        end
    end

    // data memory
    sssxo_mem #(.AW(DM_AW), .DW(8)) u_dmem (
        .sys_clk(sys_clk),
        .srst(srst),
        .we(dm_we),
        .addr(dm_addr),
        .wdata(dm_wdata),
        .rdata(dm_q)
    );

    // program memory for table reads
    sssxo_mem #(.AW(PM_AW), .DW(PM_DW)) u_pmem (
        .sys_clk(sys_clk),
        .srst(srst),
        .we(pm_we),
        .addr(pm_addr),
        .wdata(wv[PM_DW-1:0]),
        .rdata(pm_q)
    );

    // compute unit
    sssxo_alu u_alu (
        .op(cmd.op),
        .acc(accumulator),
        .mem_byte(dm_q),
        .imm(cmd.imm),
        .bitsel(cmd.bitsel),
        .flags_in(flags),
        .flags_out(alu_flags),
        .operand(alu_opnd),
        .result(alu_result),
        .to_acc(alu_to_acc),
        .to_mem(alu_to_mem),
        .skip(alu_skip)
    );

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    sequence dummy_s;
        ex_st == EX_DUM1 ##1 ex_st == EX_DUM2 ##1 ex_st == EX_IDLE;
    endsequence

    sub_carry_a: assert property ((ex_st == EX_EXEC) && (cmd.op == OP_SUB_IMM || cmd.op == OP_SUBTRACT_TO_MEMORY)
        |=> flags.c == ($past(accumulator) >= $past(alu_opnd))) // [RL1]
        else $error("carry wrong after subtract");
    sub_mem_a: assert property ((ex_st == EX_EXEC) && cmd.op == OP_SUBTRACT_TO_MEMORY
        |-> dm_we && dm_wdata == 8'(accumulator - dm_q) ##1 accumulator == $past(accumulator)) // [RL2]
        else $error("memory subtract wrong");
    sub_imm_a: assert property ((ex_st == EX_EXEC) && cmd.op == OP_SUB_IMM
        |=> accumulator == 8'($past(accumulator) - $past(alu_opnd))) // [RL3]
        else $error("immediate subtract wrong");
    swap_mem_a: assert property ((ex_st == EX_EXEC) && cmd.op == OP_NIBBLE_EXCHANGE
        |-> dm_we && dm_wdata == {dm_q[3:0], dm_q[7:4]} ##1 flags == $past(flags)) // [RL4]
        else $error("nibble exchange wrong");
    swap_acc_a: assert property ((ex_st == EX_EXEC) && cmd.op == OP_NIBBLE_EXCHANGE_TO_ACC
        |-> !dm_we ##1 accumulator == {$past(dm_q[3:0]), $past(dm_q[7:4])}) // [RL5]
        else $error("exchange to acc wrong");
    byte_skip_a: assert property ((ex_st == EX_EXEC) && cmd.op == OP_SKIP_IF_ZERO
        |-> dm_we && dm_wdata == dm_q ##1 skip_taken == ($past(dm_q) == 8'h00)) // [RL6]
        else $error("byte zero skip wrong");
    copy_skip_a: assert property ((ex_st == EX_EXEC) && cmd.op == OP_COPY_AND_SKIP_IF_ZERO
        |=> accumulator == $past(dm_q) && skip_taken == ($past(dm_q) == 8'h00)) // [RL7]
        else $error("copy and skip wrong");
    bit_skip_a: assert property ((ex_st == EX_EXEC) && cmd.op == OP_SKIP_IF_BIT_ZERO
        |=> skip_taken == $past(bit_zero)) // [RL8]
        else $error("bit zero skip wrong");
    skip_cycles_a: assert property ((ex_st == EX_EXEC) && is_skip
        |=> dummy_s and flags == $past(flags)) // [RL9]
        else $error("skip timing or flags wrong");
    tbl_data_a: assert property ((ex_st == EX_EXEC) && is_tbl
        |-> dm_we && dm_wdata == pm_q[7:0] ##1 table_high_latch == $past(pm_hi)) // [RL10]
        else $error("table read data wrong");
    tbl_last_a: assert property ((ex_st == EX_FETCH) && cmd.op == OP_TABLE_READ_LAST_PAGE
        |-> pm_addr == {LAST_PAGE, table_pointer_lower}) // [RL11]
        else $error("last page address wrong");
    xor_zero_a: assert property ((ex_st == EX_EXEC) && (cmd.op == OP_XOR_ACC || cmd.op == OP_XOR_IMM
        || cmd.op == OP_EXCLUSIVE_OR_TO_MEMORY) |=> flags.z == (($past(accumulator) ^ $past(alu_opnd)) == 8'h00)
        && flags.c == $past(flags.c) && flags.overflow_flag == $past(flags.overflow_flag)) // [RL12] [RL13] [RL14]
        else $error("xor flags wrong");
    pc_step_a: assert property ((ex_st == EX_EXEC)
        |=> prog_counter == 10'($past(prog_counter) + ($past(alu_skip) ? 10'h002 : 10'h001))) // [RL15]
        else $error("program counter step wrong");
endmodule
`default_nettype wire

// >>> verif/sssxo_bus_master.sv
// avalon-mm master model standing in for the software side
`timescale 1ns/1ps
`default_nettype none
module sssxo_bus_master (
    input wire logic sys_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [sssxo_pkg::BUS_AW-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    import sssxo_pkg::*;
    // idle bus from time zero
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
    end
    // request held until waitrequest is sampled low
    task automatic access(input logic rw, input logic [BUS_AW-1:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= ~rw;
        avs_write <= rw;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verif/sssxo_top_tb_top.sv
// self-checking bench for the sub/swap/skip/xor datapath
`timescale 1ns/1ps
`default_nettype none
module sssxo_top_tb_top;
    import sssxo_pkg::*;
    typedef struct packed {
        logic [3:0] op;
        logic [4:0] a;
        logic [2:0] b;
        logic [7:0] imm;
        logic [7:0] acc;
        logic [7:0] mem;
        logic [3:0] fl;
        logic [7:0] eacc;
        logic [7:0] emem;
        logic [3:0] efl;
        logic esk;
    } sssxo_row_t;
    logic sys_clk;
    logic srst = 1'b1;
    logic [BUS_AW-1:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, exec_busy, skip_taken;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic [9:0] exp_pc = 10'h000;
    logic sk;
    int num_errors = 0;
    int tests_run = 0;
    int nbusy;
    sssxo_row_t r;
    // op addr bit imm acc mem flags | acc mem flags skip
    sssxo_row_t rows [16] = '{
        '{4'h1, 5'h00, 3'h0, 8'h20, 8'h10, 8'h00, 4'hF, 8'hF0, 8'h00, 4'h2, 1'b0},
        '{4'h1, 5'h00, 3'h0, 8'h01, 8'h80, 8'h00, 4'h0, 8'h7F, 8'h00, 4'h9, 1'b0},
        '{4'h2, 5'h01, 3'h0, 8'h00, 8'h35, 8'h35, 4'h0, 8'h35, 8'h00, 4'h7, 1'b0},
        '{4'h2, 5'h02, 3'h0, 8'h00, 8'h00, 8'h01, 4'hF, 8'h00, 8'hFF, 4'h0, 1'b0},
        '{4'h3, 5'h1F, 3'h0, 8'h00, 8'h11, 8'hA5, 4'hB, 8'h11, 8'h5A, 4'hB, 1'b0},
        '{4'h4, 5'h05, 3'h0, 8'h00, 8'h11, 8'h3C, 4'h4, 8'hC3, 8'h3C, 4'h4, 1'b0},
        '{4'h5, 5'h06, 3'h0, 8'h00, 8'h22, 8'h00, 4'hF, 8'h22, 8'h00, 4'hF, 1'b1},
        '{4'h5, 5'h06, 3'h0, 8'h00, 8'h22, 8'h01, 4'h0, 8'h22, 8'h01, 4'h0, 1'b0},
        '{4'h6, 5'h07, 3'h0, 8'h00, 8'h77, 8'h00, 4'h5, 8'h00, 8'h00, 4'h5, 1'b1},
        '{4'h6, 5'h07, 3'h0, 8'h00, 8'h77, 8'h80, 4'hA, 8'h80, 8'h80, 4'hA, 1'b0},
        '{4'h7, 5'h08, 3'h0, 8'h00, 8'h01, 8'hFE, 4'h3, 8'h01, 8'hFE, 4'h3, 1'b1},
        '{4'h7, 5'h08, 3'h7, 8'h00, 8'h01, 8'h80, 4'hC, 8'h01, 8'h80, 4'hC, 1'b0},
        '{4'hA, 5'h09, 3'h0, 8'h00, 8'h5A, 8'h5A, 4'hB, 8'h00, 8'h5A, 4'hF, 1'b0},
        '{4'hB, 5'h0A, 3'h0, 8'h00, 8'h0F, 8'hF0, 4'h4, 8'h0F, 8'hFF, 4'h0, 1'b0},
        '{4'hC, 5'h00, 3'h0, 8'h0F, 8'h33, 8'h00, 4'hD, 8'h3C, 8'h00, 4'h9, 1'b0},
        '{4'h0, 5'h0B, 3'h0, 8'hFF, 8'h44, 8'h99, 4'h6, 8'h44, 8'h99, 4'h6, 1'b0}
    };

    sssxo_top i_sssxo_top (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .exec_busy(exec_busy), .skip_taken(skip_taken));
    sssxo_bus_master i_sssxo_bus_master (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus_wr(input logic [BUS_AW-1:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] unused;
        i_sssxo_bus_master.access(1'b1, a, d, be, unused);
    endtask

    task automatic bus_rd(input logic [BUS_AW-1:0] a);
        i_sssxo_bus_master.access(1'b0, a, 32'h0000_0000, 4'hF, q);
    endtask

    // start one instruction, count busy cycles and catch the skip pulse
    task automatic run(input logic [19:0] cmd);
        bus_wr(REG_CMD, {12'h000, cmd}, 4'hF);
        nbusy = 0;
        sk = 1'b0;
        // first look just after the completing edge, so the fetch cycle is counted
        #1;
        while (exec_busy === 1'b1 && nbusy < 50) begin
            nbusy++;
            sk = sk | skip_taken;
            @(posedge sys_clk);
            #1;
        end
    endtask

    task automatic give_verdict();
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        give_verdict();
    end

    // main sequence: reset values, table rows, table reads, back-to-back commands
    initial begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        bus_rd(REG_STAT);
        check("stat_rst", 32'h0000_0000, q);
        bus_wr(8'h18, 32'hFFFF_FFFF, 4'hF);
        bus_rd(8'h18);
        check("unmapped", 32'h0000_0000, q);
        foreach (rows[i]) begin
            r = rows[i];
            bus_wr(DM_WIN + {1'b0, r.a, 2'b00}, {24'h000000, r.mem}, 4'hF);
            bus_wr(REG_ACC, {24'h000000, r.acc}, 4'hF);
            bus_wr(REG_STAT, {24'h000000, r.fl, 4'h0}, 4'h1);
            run({r.imm, r.b, r.a, r.op});
            exp_pc = exp_pc + (r.esk ? 10'h002 : 10'h001);
            bus_rd(REG_ACC);
            check("acc", {24'h000000, r.eacc}, q);
            bus_rd(DM_WIN + {1'b0, r.a, 2'b00});
            check("mem", {24'h000000, r.emem}, q);
            bus_rd(REG_STAT);
            check("flags", {28'h0, r.efl}, {28'h0, q[7:4]});
            check("pc", {22'h0, exp_pc}, {22'h0, q[25:16]});
            check("stat_low", {30'h0, r.esk, 1'b0}, {30'h0, q[1:0]});
            check("skip", {31'h0, r.esk}, {31'h0, sk});
            check("busy", (r.op >= 4'h5 && r.op <= 4'h7) ? 32'h4 : 32'h2, nbusy);
        end
        // current page 1 and last page, same lower pointer
        bus_wr(REG_PADDR, 32'h0000_0105, 4'hF);
        bus_wr(REG_PDATA, 32'h0000_BEEF, 4'hF);
        bus_wr(REG_PADDR, 32'h0000_0305, 4'hF);
        bus_wr(REG_PDATA, 32'h0000_1234, 4'hF);
        // program word read back through the load port
        bus_wr(REG_PADDR, 32'h0000_0105, 4'hF);
        bus_rd(REG_PDATA);
        check("pdata", 32'h0000_BEEF, q);
        bus_rd(REG_PADDR);
        check("paddr", 32'h0000_0105, q);
        bus_wr(REG_TBL, 32'h0000_0105, 4'hF);
        bus_wr(REG_STAT, 32'h0000_00A0, 4'h1);
        for (int j = 0; j < 2; j++) begin
            run({11'h000, 5'(3 + j), 4'(8 + j)});
            bus_rd(DM_WIN + 8'(4 * (3 + j)));
            check("tbl_low", j ? 32'h34 : 32'hEF, q);
            bus_rd(REG_TBL);
            check("tbl_reg", j ? 32'h0012_0105 : 32'h00BE_0105, q);
            bus_rd(REG_STAT);
            check("tbl_flags", 32'hA, {28'h0, q[7:4]});
        end
        // second command issued while the first still executes
        bus_wr(REG_ACC, 32'h0000_0033, 4'hF);
        bus_wr(REG_CMD, 32'h0000_F00C, 4'hF);
        run(20'h0F00C);
        exp_pc = exp_pc + 10'h004;
        bus_rd(REG_ACC);
        check("acc_b2b", 32'h0000_0033, q);
        bus_rd(REG_STAT);
        check("pc_b2b", {22'h0, exp_pc}, {22'h0, q[25:16]});
        // reset after the last command has finished clears acc, flags, pc and pointers
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        bus_rd(REG_STAT);
        check("stat_rst2", 32'h0000_0000, q);
        bus_rd(REG_ACC);
        check("acc_rst2", 32'h0000_0000, q);
        bus_rd(REG_TBL);
        check("tbl_rst2", 32'h0000_0000, q);
        give_verdict();
    end
endmodule
`default_nettype wire
